/* File: logic/otmb_pkg.sv */
package otmb_pkg;
  // Bus widths
  localparam int OTMB_ADDR_W = 32;
  localparam int OTMB_DATA_W = 32;
  localparam int OTMB_BE_W = 4;
  localparam int OTMB_NUM_DEV = 2;
  // Input register stage on the memory data is built in by default
  localparam int OTMB_REG_IN_DEFAULT = 1;
  // Pin-side hold time for one access, in clock cycles, per device
  localparam logic [3:0] OTMB_WAIT_DEFAULT = 4'h2;
  // Reset values
  localparam logic [OTMB_ADDR_W-1:0] OTMB_ADDR_RST = 32'h0000_0000;
  localparam logic [OTMB_DATA_W-1:0] OTMB_DATA_RST = 32'h0000_0000;

  // Request from the on-chip master side
  typedef struct packed {
    logic rd;
    logic wr;
    logic [OTMB_ADDR_W-1:0] addr;
    logic [OTMB_BE_W-1:0] be;
    logic [OTMB_DATA_W-1:0] wdata;
  } otmb_req_s;

  // Pin-side control group, driven from flip-flops
  typedef struct packed {
    logic rd_b;
    logic wr_b;
    logic [OTMB_NUM_DEV-1:0] cs_b;
    logic [OTMB_BE_W-1:0] be_b;
    logic [OTMB_ADDR_W-1:0] addr;
  } otmb_pin_s;

  // Bridge sequencer states
  typedef enum logic [3:0] {
    OTMB_IDLE = 4'b0001,
    OTMB_XFER = 4'b0010,
    OTMB_CAPT = 4'b0100,
    OTMB_DONE = 4'b1000
  } otmb_state_e;
endpackage : otmb_pkg

/* File: logic/otmb_bridge.sv */
// What this block does
// - Registered-input build registers every memory-side input
// - Unregistered build passes memory outputs straight through
// - Every pin-bound signal always comes from a register
// - Each register stage adds exactly one read cycle
// - Pin sequence and duration unchanged by stages
// - No own address; address forwarded unchanged
// - One shared pin set; accesses mutually exclusive
// - Drive data pins on writes, release otherwise
// - On-chip slave port, off-chip tristate master port
// - Single clock sets off-chip cycle time
// - Full 32-bit byte address space reachable
// - Pin address is a byte address
// - Registered input stage adds one read cycle
`timescale 1ns/100ps
module otmb_bridge #(
  parameter int REG_IN = otmb_pkg::OTMB_REG_IN_DEFAULT
) (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  // On-chip slave port
  input wire otmb_pkg::otmb_req_s REQ_IN,
  input wire logic [otmb_pkg::OTMB_NUM_DEV-1:0] DEV_SEL_IN,
  input wire logic [3:0] WAIT_CYCLES_IN,
  output logic WAIT_REQ_OUT,
  output logic RDATA_VALID_OUT,
  output logic [otmb_pkg::OTMB_DATA_W-1:0] RDATA_OUT,
  // Off-chip tristate master port
  output otmb_pkg::otmb_pin_s PIN_OUT,
  output logic [otmb_pkg::OTMB_DATA_W-1:0] DATA_OUT,
  output logic DATA_OE_OUT,
  input wire logic [otmb_pkg::OTMB_DATA_W-1:0] DATA_IN
);
  import otmb_pkg::*;

  // Sequencer state
  otmb_state_e state;
  otmb_state_e next_state;
  logic [3:0] hold_cnt;
  logic [3:0] next_hold_cnt;
  logic is_read;
  logic next_is_read;

  // Pin-side registers
  otmb_pin_s pin;
  otmb_pin_s next_pin;
  logic [OTMB_DATA_W-1:0] wdata;
  logic [OTMB_DATA_W-1:0] next_wdata;
  logic data_oe;
  logic next_data_oe;

  // Read return registers
  logic [OTMB_DATA_W-1:0] rdata;
  logic [OTMB_DATA_W-1:0] next_rdata;
  logic rvalid;
  logic next_rvalid;

  // Accept handshake
  logic wait_req;
  logic next_wait_req;

  // Memory-side data after the optional input stage
  logic [OTMB_DATA_W-1:0] data_in_q;
  logic [OTMB_DATA_W-1:0] data_seen;

  // Keeps one device selected at most; a bad multi-hot select deselects all
  function automatic logic [OTMB_NUM_DEV-1:0] one_hot_cs_b(
    input logic [OTMB_NUM_DEV-1:0] sel
  );
    logic [OTMB_NUM_DEV-1:0] res;
    res = '1;
    if (sel != '0 && (sel & (sel - 1'b1)) == '0) begin
      res = ~sel;
    end
    return res;
  endfunction : one_hot_cs_b

  // Input stage: built in or left out, latency follows the choice
  // Memory data is taken as synchronous to the clock: the device's access
  // time must fit inside the hold count chosen for it
  generate
    if (REG_IN != 0) begin : g_reg_in
      always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
          data_in_q <= OTMB_DATA_RST;
        end else begin
          data_in_q <= DATA_IN;
        end
      end
      assign data_seen = data_in_q;
    end else begin : g_no_reg_in
      // Tie-off keeps the unused stage signal driven
      assign data_in_q = OTMB_DATA_RST;
      assign data_seen = DATA_IN;
    end
  endgenerate

  // Sequencer: one access on the shared pins at a time
  always_comb begin
    next_state = state;
    next_hold_cnt = hold_cnt;
    next_is_read = is_read;
    next_pin = pin;
    next_wdata = wdata;
    next_data_oe = data_oe;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    case (state)
      OTMB_IDLE: begin
        // A request still held in the accept cycle must not start a second access
        if (wait_req && (REQ_IN.rd || REQ_IN.wr)) begin
          next_pin.addr = REQ_IN.addr;
          next_pin.cs_b = one_hot_cs_b(DEV_SEL_IN);
          next_pin.be_b = ~REQ_IN.be;
          next_pin.rd_b = ~REQ_IN.rd;
          next_pin.wr_b = REQ_IN.rd;
          next_wdata = REQ_IN.wdata;
          next_data_oe = ~REQ_IN.rd;
          next_is_read = REQ_IN.rd;
          // Pin hold length depends only on the device timing, not on stages
          next_hold_cnt = (WAIT_CYCLES_IN == 4'h0) ? 4'h1 : WAIT_CYCLES_IN;
          next_state = OTMB_XFER;
        end
      end
      OTMB_XFER: begin
        next_hold_cnt = hold_cnt - 4'h1;
        if (hold_cnt == 4'h1) begin
          // All strobes drop together; the address stays where it was
          next_pin.cs_b = '1;
          next_pin.rd_b = 1'b1;
          next_pin.wr_b = 1'b1;
          next_pin.be_b = '1;
          next_data_oe = 1'b0;
          if (is_read && REG_IN != 0) begin
            next_state = OTMB_CAPT; // extra input stage cycle
          end else begin
            next_state = OTMB_DONE;
            next_rvalid = is_read;
            next_rdata = is_read ? data_seen : rdata;
          end
        end
      end
      OTMB_CAPT: begin
        // Data registered at the release edge is returned one cycle later
        next_rdata = data_seen;
        next_rvalid = 1'b1;
        next_state = OTMB_DONE;
      end
      OTMB_DONE: begin
        // Strobes are already idle; the handshake goes low in the cycle after this state
        next_state = OTMB_IDLE;
      end
      default: begin
        // Unused codes fall back to idle
        next_state = OTMB_IDLE;
      end
    endcase
  end

  // Accept handshake: low for exactly one cycle once the access has ended.
  // The master still holds its request in that cycle, so the sequencer
  // only looks for a new request while this is high.
  always_comb begin
    next_wait_req = 1'b1;
    if (state == OTMB_DONE) begin
      next_wait_req = 1'b0;
    end
  end

  // Sequencer registers; the hold count depends only on device timing,
  // so the input stage never stretches the pin-side access
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state <= OTMB_IDLE;
      hold_cnt <= 4'h0;
      is_read <= 1'b0;
    end else begin
      state <= next_state;
      hold_cnt <= next_hold_cnt;
      is_read <= next_is_read;
    end
  end

  // Pin registers; every pin-bound signal leaves from here, never from logic
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      pin <= '{rd_b: 1'b1, wr_b: 1'b1, cs_b: '1, be_b: '1, addr: OTMB_ADDR_RST};
      wdata <= OTMB_DATA_RST;
      data_oe <= 1'b0;
    end else begin
      pin <= next_pin;
      wdata <= next_wdata;
      data_oe <= next_data_oe;
    end
  end

  // Read return registers; data holds until the next read so a slow
  // master may still pick it up after the valid pulse
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rdata <= OTMB_DATA_RST;
      rvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // Handshake register; high out of reset so nothing is accepted
  // before the sequencer is ready
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      wait_req <= 1'b1;
    end else begin
      wait_req <= next_wait_req;
    end
  end

  // Port outputs straight from flip-flops
  assign PIN_OUT = pin;
  assign DATA_OUT = wdata;
  assign DATA_OE_OUT = data_oe;
  assign RDATA_OUT = rdata;
  assign RDATA_VALID_OUT = rvalid;
  assign WAIT_REQ_OUT = wait_req; // Low for one cycle: the request is accepted then
endmodule : otmb_bridge

/* File: bench/otmb_bridge_asserts.sv */
`timescale 1ns/100ps
module otmb_bridge_asserts import otmb_pkg::*; #(parameter int REG_IN = 1) (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic WAIT_REQ_OUT,
  input wire logic RDATA_VALID_OUT,
  input wire logic DATA_OE_OUT,
  input wire otmb_req_s REQ_IN,
  input wire logic [OTMB_NUM_DEV-1:0] DEV_SEL_IN,
  input wire logic [3:0] WAIT_CYCLES_IN,
  input wire logic [OTMB_DATA_W-1:0] RDATA_OUT,
  input wire logic [OTMB_DATA_W-1:0] DATA_OUT,
  input wire logic [OTMB_DATA_W-1:0] DATA_IN,
  input wire otmb_pin_s PIN_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  // Start of a pin-side read or write
  sequence rd_go; $fell(PIN_OUT.rd_b); endsequence
  sequence wr_go; $fell(PIN_OUT.wr_b); endsequence
  one_sel_a: assert property ($countones(~PIN_OUT.cs_b) <= 1) else $error("two selects");
  oe_write_a: assert property (DATA_OE_OUT |-> !PIN_OUT.wr_b) else $error("oe off write");
  addr_pass_a: assert property (($fell(PIN_OUT.rd_b) || $fell(PIN_OUT.wr_b))
    |-> PIN_OUT.addr == $past(REQ_IN.addr)) else $error("addr changed");
  sel_pass_a: assert property (($fell(PIN_OUT.rd_b) || $fell(PIN_OUT.wr_b))
    && $onehot($past(DEV_SEL_IN)) |-> ~PIN_OUT.cs_b == $past(DEV_SEL_IN)) else $error("bad cs");
  rd_hold_a: assert property (rd_go ##0 $past(WAIT_CYCLES_IN) == 4'h3
    |-> (!PIN_OUT.rd_b) [*3] ##1 PIN_OUT.rd_b) else $error("read hold");
  rd_valid_a: assert property ($rose(PIN_OUT.rd_b) |-> ##REG_IN RDATA_VALID_OUT)
    else $error("valid late");
  rd_data_a: assert property ($rose(RDATA_VALID_OUT)
    |-> RDATA_OUT == $past(DATA_IN, REG_IN + 1)) else $error("rdata");
  wr_data_a: assert property (wr_go |-> DATA_OE_OUT && DATA_OUT == $past(REQ_IN.wdata))
    else $error("wdata");
  accept_once_a: assert property (!WAIT_REQ_OUT |=> WAIT_REQ_OUT)
    else $error("accept long");
  no_retake_a: assert property (!WAIT_REQ_OUT |=> PIN_OUT.rd_b && PIN_OUT.wr_b)
    else $error("request taken twice");
endmodule : otmb_bridge_asserts
bind otmb_bridge otmb_bridge_asserts #(.REG_IN(REG_IN)) u_asserts (.*);

/* File: bench/otmb_mem_model.sv */
`timescale 1ns/100ps
module otmb_mem_model import otmb_pkg::*; (
  input wire logic CLK_IN,
  input wire otmb_pin_s PIN_IN,
  input wire logic [OTMB_DATA_W-1:0] BUS_IN,
  output logic [OTMB_DATA_W-1:0] DRV_OUT = '0
);
  logic [OTMB_DATA_W-1:0] mem [16];
  // Word memory: the two byte-address lines are not wired
  always @(posedge CLK_IN) if (!PIN_IN.wr_b && !PIN_IN.cs_b[0]) mem[PIN_IN.addr[5:2]] <= BUS_IN;
  // Drives only while selected for a read; a toggling pattern otherwise
  always @(posedge CLK_IN) DRV_OUT <= !PIN_IN.rd_b && !PIN_IN.cs_b[0] ? mem[PIN_IN.addr[5:2]]
    : ~DRV_OUT;
endmodule : otmb_mem_model

/* File: bench/tb_otmb_bridge.sv */
`timescale 1ns/100ps
module tb_otmb_bridge;
  import otmb_pkg::*;
  localparam int IN_STAGE = OTMB_REG_IN_DEFAULT;
  logic CLK_IN = 0, RST_B_IN = 0, WAIT_REQ_OUT, RDATA_VALID_OUT, DATA_OE_OUT;
  otmb_req_s REQ_IN = '0;
  otmb_pin_s PIN_OUT;
  logic [1:0] DEV_SEL_IN = 2'h1;
  logic [3:0] WAIT_CYCLES_IN = OTMB_WAIT_DEFAULT;
  logic [31:0] RDATA_OUT, DATA_OUT, DATA_IN, drv;
  int n_fail = 0, tests_run = 0;
  // Shared pin level: the bridge wins while its enable is high
  assign DATA_IN = DATA_OE_OUT ? DATA_OUT : drv;
  otmb_bridge #(.REG_IN(IN_STAGE)) u_dut (.CLK_IN, .RST_B_IN, .REQ_IN, .DEV_SEL_IN,
    .WAIT_CYCLES_IN,
    .WAIT_REQ_OUT, .RDATA_VALID_OUT, .RDATA_OUT, .PIN_OUT, .DATA_OUT, .DATA_OE_OUT, .DATA_IN);
  otmb_mem_model u_mem (.CLK_IN, .PIN_IN(PIN_OUT), .BUS_IN(DATA_IN), .DRV_OUT(drv));
  initial forever #12.5 CLK_IN = ~CLK_IN;
  task automatic chk(input string s, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // One access; checks strobes, select, address, read data and latency
  task automatic acc(input logic rd, input logic [31:0] a, d, input logic [1:0] s,
    input logic [3:0] n);
    int i;
    int hold;
    int seen;
    hold = (n == 4'h0) ? 1 : int'(n);
    seen = 0;
    @(posedge CLK_IN);
    REQ_IN <= '{rd, !rd, a, 4'hF, d};
    DEV_SEL_IN <= s;
    WAIT_CYCLES_IN <= n;
    // Iteration i looks at the values launched by the edge before it
    for (i = 0; i < 40 && WAIT_REQ_OUT !== 0; i++) begin
      @(posedge CLK_IN);
      if (i == 1) chk("cs", {30'h0, $onehot(s) ? ~s : 2'h3}, {30'h0, PIN_OUT.cs_b});
      if (i == 1) chk("addr", a, PIN_OUT.addr);
      if (i == 1) chk("strobes", {26'h0, !rd, rd, 4'h0},
        {26'h0, PIN_OUT.rd_b, PIN_OUT.wr_b, PIN_OUT.be_b});
      if (i == 1) chk("oe", {31'h0, !rd}, {31'h0, DATA_OE_OUT});
      if (i == hold + 1) chk("release", 32'h1,
        {31'h0, PIN_OUT.rd_b & PIN_OUT.wr_b & (&PIN_OUT.cs_b) & !DATA_OE_OUT});
      if (RDATA_VALID_OUT === 1) begin
        seen++;
        chk("rdata", d, RDATA_OUT);
        chk("lat", 32'(hold + 1 + IN_STAGE), i);
      end
    end
    if (i == 40) begin
      n_fail++;
      tally_and_finish();
    end
    chk("valids", {31'h0, rd}, seen);
    chk("accept", 32'(hold + 3 + (rd ? IN_STAGE : 0)), i);
    REQ_IN <= '0;
  endtask : acc
  initial begin
    repeat (6) @(posedge CLK_IN);
    RST_B_IN <= 1;
    chk("waitreq", 1, {31'h0, WAIT_REQ_OUT});
    acc(0, 32'h0000_0010, 32'hA5A5_0001, 2'h1, 4'h2);
    acc(1, 32'h0000_0010, 32'hA5A5_0001, 2'h1, 4'h2);
    acc(0, 32'hFFFF_FFFC, 32'h5A5A_0002, 2'h1, 4'h1);
    acc(1, 32'hFFFF_FFFC, 32'h5A5A_0002, 2'h1, 4'h3);
    acc(0, 32'h0000_0010, 32'h0000_0C0C, 2'h2, 4'h0);
    acc(0, 32'h0000_0010, 32'h0000_0BAD, 2'h3, 4'h2);
    acc(1, 32'h0000_0010, 32'hA5A5_0001, 2'h1, 4'h2);
    tally_and_finish();
  end
endmodule : tb_otmb_bridge
